// ---- core/pump_pkg.sv ----
// Package for the charge pump mode control block: offsets, field positions, reset values, types.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package pump_pkg;

	// The printed offset is not a multiple of four, so it is a register index.
	localparam logic [7:0] MODE_INDEX = 8'h95;
	localparam logic [9:0] MODE_ADDR = {MODE_INDEX, 2'b00};
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] WRITE_MASK = 8'hF7;

	localparam int BIT_ENABLE = 0;
	localparam int BIT_ALWAYS_ON = 1;
	localparam int BIT_AUTOMATIC = 2;
	localparam int BIT_STATUS = 3;
	localparam int BIT_EXC_ENABLE = 4;
	localparam int BIT_EXC_LEVEL = 5;
	localparam int BIT_SUPPLY_ENABLE = 6;
	localparam int BIT_COMMON_ENABLE = 7;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_REG_ONLY = 2'b01,
		MODE_ALWAYS_ON = 2'b10,
		MODE_AUTO = 2'b11
	} pump_mode_t;

	typedef struct packed {
		logic pump_on;
		logic regulator_on;
		logic analog_supply_on;
		logic excitation_on;
		logic excitation_high;
		logic common_mode_on;
	} analog_ctrl_t;

endpackage

// ---- core/pump_mode_decode.sv ----
// Decodes the pump mode and the pump run request from the control bits and the supply comparator.
// Assumes supply_high_i is already synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module pump_mode_decode
(
	// Control bits
	input wire logic enable_i,
	input wire logic always_on_i,
	input wire logic automatic_i,
	// Supply comparator, high while supply is above 4.1V
	input wire logic supply_high_i,
	// Decoded mode and pump request
	output pump_pkg::pump_mode_t mode_o,
	output logic pump_run_o
);

	always_comb
	begin
		if (!enable_i)
			mode_o = pump_pkg::MODE_OFF;
		else if (always_on_i)
			mode_o = pump_pkg::MODE_ALWAYS_ON;
		else if (automatic_i)
			mode_o = pump_pkg::MODE_AUTO;
		else
			mode_o = pump_pkg::MODE_REG_ONLY;
	end

	always_comb
	begin
		unique case (mode_o)
			pump_pkg::MODE_OFF: pump_run_o = 1'b0;
			pump_pkg::MODE_REG_ONLY: pump_run_o = 1'b0;
			pump_pkg::MODE_ALWAYS_ON: pump_run_o = 1'b1;
			pump_pkg::MODE_AUTO: pump_run_o = !supply_high_i;
		endcase
	end

endmodule
`default_nettype wire

// ---- core/wb_byte_slave.sv ----
// Classic Wishbone slave front end: one-cycle registered ack, address decode, byte lane 0 select.
// Assumes a single-cycle master that holds the request until ack.
`timescale 1ns/1ns
`default_nettype none
module wb_byte_slave
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone request
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	// Decoded access: ack and write strobe are one-cycle pulses at the acking edge, hit is a plain address match
	output logic ack_o,
	output logic hit_o,
	output logic wr_o
);

	logic ack_reg;
	logic ack_next;

	always_comb
	begin
		ack_next = cyc_i && stb_i && !ack_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= ack_next;
	end

	// Unmapped addresses still ack and read zero, so a stray access never hangs the bus
	assign ack_o = ack_reg;
	assign hit_o = (adr_i[31:0] == {22'h00_0000, pump_pkg::MODE_ADDR});
	assign wr_o = cyc_i && stb_i && ack_next && we_i && hit_o && sel_i[0];

endmodule
`default_nettype wire

// ---- core/charge_pump_mode_control.sv ----
// Charge pump mode register with decode of the analog enables.
// Assumes a classic Wishbone master and a comparator input synchronous to clk_i.
//
// Summary of operation
// - Enable bit clear keeps pump and regulator off; set enables them per mode.
// - Always-on acts only while enabled; set forces pump continuously on.
// - Automatic bit set enables supply-dependent pump control; clear disables it.
// - Read-only status bit shows pump running in automatic mode.
// - Excitation enable bit turns excitation output on or off.
// - Common-mode enable turns common-mode reference and 1.2V output on or off.
// - Enable, always-on, automatic decode into off, regulator-only, always-on or automatic modes.
// - Automatic mode: supply above 4.1V stops pump, status 0; else runs, status 1.
// - Enabled with both mode bits clear: pump off, regulator on.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module charge_pump_mode_control
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Analog side
	input wire logic supply_high_i,
	output pump_pkg::analog_ctrl_t analog_o,
	output pump_pkg::pump_mode_t mode_o
);

	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic status_reg;
	logic status_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	pump_pkg::analog_ctrl_t analog_reg;
	pump_pkg::analog_ctrl_t analog_next;
	logic hit;
	logic wr;
	logic pump_run;
	pump_pkg::pump_mode_t mode;

	wb_byte_slave wb_byte_slave_i
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.ack_o(ack_o),
		.hit_o(hit),
		.wr_o(wr)
	);

	pump_mode_decode pump_mode_decode_i
	(
		.enable_i(mode_reg[pump_pkg::BIT_ENABLE]),
		.always_on_i(mode_reg[pump_pkg::BIT_ALWAYS_ON]),
		.automatic_i(mode_reg[pump_pkg::BIT_AUTOMATIC]),
		.supply_high_i(supply_high_i),
		.mode_o(mode),
		.pump_run_o(pump_run)
	);

	always_comb
	begin
		mode_next = mode_reg;
		if (wr)
			mode_next = dat_i[7:0] & pump_pkg::WRITE_MASK;
		// Status is only meaningful in automatic mode, so it reads zero otherwise
		status_next = (mode == pump_pkg::MODE_AUTO) && pump_run;
		analog_next.pump_on = pump_run;
		analog_next.regulator_on = mode_reg[pump_pkg::BIT_ENABLE];
		analog_next.analog_supply_on = mode_reg[pump_pkg::BIT_SUPPLY_ENABLE];
		analog_next.excitation_on = mode_reg[pump_pkg::BIT_EXC_ENABLE];
		analog_next.excitation_high = mode_reg[pump_pkg::BIT_EXC_LEVEL];
		analog_next.common_mode_on = mode_reg[pump_pkg::BIT_COMMON_ENABLE];
		dat_next = 32'h0000_0000;
		if (hit)
		begin
			dat_next[7:0] = mode_reg;
			dat_next[pump_pkg::BIT_STATUS] = status_reg;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_reg <= pump_pkg::MODE_RESET;
			status_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			analog_reg <= '0;
		end
		else
		begin
			mode_reg <= mode_next;
			status_reg <= status_next;
			dat_reg <= dat_next;
			analog_reg <= analog_next;
		end
	end

	assign dat_o = dat_reg;
	assign analog_o = analog_reg;
	assign mode_o = mode;

	property p_off;
		@(posedge clk_i) disable iff (rst_i)
		!mode_reg[pump_pkg::BIT_ENABLE] |=> !analog_o.pump_on && !analog_o.regulator_on;
	endproperty
	a_off: assert property (p_off) else $error("pump or regulator on while disabled");

	property p_always_on;
		@(posedge clk_i) disable iff (rst_i)
		mode_reg[pump_pkg::BIT_ENABLE] && mode_reg[pump_pkg::BIT_ALWAYS_ON] |=> analog_o.pump_on;
	endproperty
	a_always_on: assert property (p_always_on) else $error("always-on pump not running");

	property p_auto_high;
		@(posedge clk_i) disable iff (rst_i)
		// Pump flag and status are launched by the same edge, so a later cycle may already see a low supply
		mode == pump_pkg::MODE_AUTO && supply_high_i |=> !analog_o.pump_on && !status_reg;
	endproperty
	a_auto_high: assert property (p_auto_high) else $error("pump runs above threshold");

	property p_auto_low;
		@(posedge clk_i) disable iff (rst_i)
		mode == pump_pkg::MODE_AUTO && !supply_high_i |=> analog_o.pump_on && status_reg;
	endproperty
	a_auto_low: assert property (p_auto_low) else $error("pump idle at low supply");

	property p_reg_only;
		@(posedge clk_i) disable iff (rst_i)
		mode_reg[2:0] == 3'h1 |=> !analog_o.pump_on && analog_o.regulator_on;
	endproperty
	a_reg_only: assert property (p_reg_only) else $error("regulator-only mode wrong");

	property p_priority;
		@(posedge clk_i) disable iff (rst_i)
		mode_reg[2:0] == 3'h7 |-> mode == pump_pkg::MODE_ALWAYS_ON;
	endproperty
	a_priority: assert property (p_priority) else $error("always-on lost priority");

	property p_write;
		@(posedge clk_i) disable iff (rst_i)
		wr |=> mode_reg == ($past(dat_i[7:0]) & pump_pkg::WRITE_MASK) ##1 analog_o.excitation_on == mode_reg[4];
	endproperty
	a_write: assert property (p_write) else $error("write did not update mode");

	property p_levels;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> analog_o.common_mode_on == $past(mode_reg[7]) && analog_o.analog_supply_on == $past(mode_reg[6])
			&& analog_o.excitation_high == $past(mode_reg[5]);
	endproperty
	a_levels: assert property (p_levels) else $error("analog enables mismatch");

	property p_mode_decode;
		@(posedge clk_i) disable iff (rst_i)
		mode_reg[0] && !mode_reg[1] && mode_reg[2] |-> mode == pump_pkg::MODE_AUTO;
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("automatic mode not decoded");

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

	// Status never reads a stale run flag outside automatic mode
	property p_status_off;
		@(posedge clk_i) disable iff (rst_i)
		mode != pump_pkg::MODE_AUTO |=> !status_reg;
	endproperty
	a_status_off: assert property (p_status_off) else $error("status set outside automatic mode");

	property p_status_ro;
		@(posedge clk_i) disable iff (rst_i)
		wr |=> !mode_reg[pump_pkg::BIT_STATUS];
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status bit stored by a write");

	property p_read_data;
		@(posedge clk_i) disable iff (rst_i)
		ack_o && hit |-> dat_o[7:0] == {$past(mode_reg[7:4]), $past(status_reg), $past(mode_reg[2:0])};
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data differs from register");

	property p_unmapped_zero;
		@(posedge clk_i) disable iff (rst_i)
		ack_o && !hit |-> dat_o == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	// A registered ack answers every new request in the next cycle, so the bus never stalls
	property p_ack_answer;
		@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

	property p_ignored_write;
		@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && we_i && !ack_o && (!sel_i[0] || !hit) |=> mode_reg == $past(mode_reg);
	endproperty
	a_ignored_write: assert property (p_ignored_write) else $error("ignored write changed mode");

	property p_excitation;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> analog_o.excitation_on == $past(mode_reg[pump_pkg::BIT_EXC_ENABLE]);
	endproperty
	a_excitation: assert property (p_excitation) else $error("excitation enable mismatch");

	property p_regulator;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> analog_o.regulator_on == $past(mode_reg[pump_pkg::BIT_ENABLE]);
	endproperty
	a_regulator: assert property (p_regulator) else $error("regulator does not follow enable");

	// No disable here, so the reset branch itself is checked
	property p_reset_values;
		@(posedge clk_i)
		rst_i |=> mode_reg == pump_pkg::MODE_RESET && analog_o == '0 && !ack_o && dat_o == 32'h0000_0000;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("state not cleared by reset");

	c_auto: cover property (@(posedge clk_i) disable iff (rst_i) mode == pump_pkg::MODE_AUTO && status_reg);
	c_always: cover property (@(posedge clk_i) disable iff (rst_i) mode == pump_pkg::MODE_ALWAYS_ON);
	c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr ##1 ack_o);
	c_reg_only: cover property (@(posedge clk_i) disable iff (rst_i) mode == pump_pkg::MODE_REG_ONLY);
	c_auto_stop: cover property (@(posedge clk_i) disable iff (rst_i)
		mode == pump_pkg::MODE_AUTO && supply_high_i ##1 !analog_o.pump_on);

endmodule
`default_nettype wire

// ---- sim/supply_model.sv ----
// Supply comparator model: reports whether the supply sits above the 4.1V trip point.
// Assumes the bench commands the supply level; output is synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module supply_model
(
	// Clock
	input wire logic clk_i,
	// Commanded supply level, high for above 4.1V
	input wire logic above_i,
	// Comparator output
	output logic supply_high_o
);
	// Registered so the comparator never moves in the sampling step of the block
	always_ff @(posedge clk_i)
	begin
		supply_high_o <= above_i;
	end
endmodule
`default_nettype wire

// ---- sim/charge_pump_mode_control_tb_top.sv ----
// Self-checking bench for the charge pump mode register over classic Wishbone.
// Assumes one-cycle registered ack and the supply comparator model at the analog side.
`timescale 1ns/1ns
`default_nettype none
module charge_pump_mode_control_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0000_0000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic above = 1'b1;
	logic supply_high;
	logic [31:0] dat_o;
	logic ack_o;
	pump_pkg::analog_ctrl_t analog_o;
	pump_pkg::pump_mode_t mode_o;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] q;
	localparam logic [31:0] ADDR = {22'h00_0000, pump_pkg::MODE_ADDR};

	charge_pump_mode_control charge_pump_mode_control_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.supply_high_i(supply_high), .analog_o(analog_o), .mode_o(mode_o));
	supply_model supply_model_i (.clk_i(clk_i), .above_i(above), .supply_high_o(supply_high));

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds the request until ack is sampled high, then releases it
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		check(32'(n < 20), 32'h0000_0001);
	endtask

	task automatic reset_dut(input int n);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADDR, 8'h00, 4'hF);
		check(q, 32'h0000_0000);
		check(32'(analog_o), 32'h0000_0000);
		check(32'(mode_o), 32'h0000_0000);
	endtask

	// Every mode-bit combination at both supply levels; bit 3 is written 1 and must read back as status
	task automatic test_modes();
		pump_pkg::pump_mode_t pm;
		logic sts;
		for (int i = 0; i < 16; i++)
		begin
			above <= i[3];
			wb(1'b1, ADDR, {4'h0, 1'b1, i[2:0]}, 4'h1);
			repeat (3) @(posedge clk_i);
			if (!i[0])
				pm = pump_pkg::MODE_OFF;
			else if (i[1])
				pm = pump_pkg::MODE_ALWAYS_ON;
			else if (i[2])
				pm = pump_pkg::MODE_AUTO;
			else
				pm = pump_pkg::MODE_REG_ONLY;
			sts = pm == pump_pkg::MODE_AUTO && !i[3];
			check(32'(mode_o), 32'(pm));
			check(32'(analog_o.pump_on), 32'(pm == pump_pkg::MODE_ALWAYS_ON || sts));
			check(32'(analog_o.regulator_on), 32'(i[0]));
			wb(1'b0, ADDR, 8'h00, 4'hF);
			check(q, {24'h00_0000, 4'h0, sts, i[2:0]});
		end
	endtask

	// Analog output fields, then an ignored write with lane 0 off and an unmapped place
	task automatic test_fields();
		logic [7:0] v [3] = '{8'hB0, 8'h50, 8'h00};
		for (int i = 0; i < 3; i++)
		begin
			wb(1'b1, ADDR, v[i], 4'h1);
			repeat (2) @(posedge clk_i);
			check(32'(analog_o.excitation_on), 32'(v[i][4]));
			check(32'(analog_o.excitation_high), 32'(v[i][5]));
			check(32'(analog_o.analog_supply_on), 32'(v[i][6]));
			check(32'(analog_o.common_mode_on), 32'(v[i][7]));
		end
		wb(1'b1, ADDR, 8'hF1, 4'hE);
		wb(1'b1, ADDR + 32'h0000_0004, 8'hF1, 4'h1);
		wb(1'b0, ADDR + 32'h0000_0004, 8'h00, 4'hF);
		check(q, 32'h0000_0000);
		wb(1'b0, ADDR, 8'h00, 4'hF);
		check(q, 32'h0000_0000);
		wb(1'b1, ADDR, 8'hF7, 4'h1);
	endtask

	// Recommended set-up in automatic mode, then the supply sags below the trip point
	task automatic test_recommended();
		wb(1'b1, ADDR, 8'h05, 4'h1);
		wb(1'b0, ADDR, 8'h00, 4'hF);
		check(q, 32'h0000_0005);
		check(32'(analog_o.pump_on), 32'h0000_0000);
		above <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(32'(analog_o.pump_on), 32'h0000_0001);
		wb(1'b0, ADDR, 8'h00, 4'hF);
		check(q, 32'h0000_000D);
	endtask

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			finish_test();
		end
	end

	initial
	begin
		reset_dut(12);
		test_modes();
		test_fields();
		reset_dut(2);
		test_recommended();
		finish_test();
	end
endmodule
`default_nettype wire
